// >>> logic/accel_status_output_regs.sv
/*
 * Status and sample output register bank of a three-axis motion sensor,
 * an Avalon-MM slave with waitrequest, plus a masked level interrupt.
 * Assumes the sensor core and queue run on sys_clk and present their
 * state as same-domain inputs; the sample strobe is a one-cycle pulse.
 */
// Decided for this implementation: the Avalon-MM register port.
// Notes on behaviour
// - New-sample flag set; cleared by reading high byte.
// - Watermark flag: fill count at or above level.
// - Overrun flag set when queue overwrote data.
// - X low byte: low part, four zeros.
// - X high byte returns bits 15:8.
`timescale 1ns/100ps
`default_nettype none
module accel_status_output_regs (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic sample_strobe,
    input wire accel_regs_pkg::sample_t sample_in,
    input wire logic powerdown_indicator,
    input wire logic [7:0] queue_sample_count,
    input wire logic queue_overwrite,
    output logic [6:0] watermark_level,
    output logic irq
);
    // ==========================================================
    // State
    // ==========================================================
    accel_regs_pkg::sample_t sample_word;
    accel_regs_pkg::sample_t next_sample_word;
    logic new_sample_flag;
    logic next_new_sample_flag;
    logic queue_overrun;
    logic next_queue_overrun;
    logic [6:0] next_watermark_level;
    logic [2:0] irq_status;
    logic [2:0] next_irq_status;
    logic [2:0] irq_mask;
    logic [2:0] next_irq_mask;
    logic [31:0] next_readdata;
    logic ack;
    logic next_ack;
    logic watermark_reached;
    logic wm_prev;
    logic [7:0] index;
    logic rd_take;
    logic wr_take;
    logic [7:0] rd_byte;
    logic [15:0] x_sample_word;
    logic [15:0] y_sample_word;
    logic [15:0] z_sample_word;
    logic hi_read;
    logic wm_rise;
    logic next_wm_prev;
    logic wr_watermark;
    logic wr_mask;
    logic rd_irq_status;

    assign index = address[9:2];
    // Each access is answered one cycle late, so waitrequest drops on the second cycle.
    assign waitrequest = (read | write) & ~ack;
    assign rd_take = read & ~ack;
    assign wr_take = write & ~ack & byteenable[0];
    assign x_sample_word = {sample_word.x, 4'h0};
    assign y_sample_word = {sample_word.y, 4'h0};
    assign z_sample_word = {sample_word.z, 4'h0};
    assign watermark_reached = ({1'b0, watermark_level} <= queue_sample_count);
    assign irq = |(irq_status & irq_mask);

    // ==========================================================
    // Read decode
    // ==========================================================
    always_comb begin
        rd_byte = 8'h00;
        case (index)
            accel_regs_pkg::IDX_SENSOR_STATUS: begin
                rd_byte[accel_regs_pkg::BIT_NEW_SAMPLE] = new_sample_flag;
                rd_byte[accel_regs_pkg::BIT_POWERDOWN] = powerdown_indicator;
            end
            accel_regs_pkg::IDX_QUEUE_STATUS_FLAGS: begin
                rd_byte[accel_regs_pkg::BIT_WATERMARK] = watermark_reached;
                rd_byte[accel_regs_pkg::BIT_OVERRUN] = queue_overrun;
            end
            accel_regs_pkg::IDX_QUEUE_FILL_COUNT: rd_byte = queue_sample_count;
            accel_regs_pkg::IDX_X_ACCEL_LOW: rd_byte = x_sample_word[7:0];
            accel_regs_pkg::IDX_X_ACCEL_HIGH: rd_byte = x_sample_word[15:8];
            accel_regs_pkg::IDX_Y_ACCEL_LOW: rd_byte = y_sample_word[7:0];
            accel_regs_pkg::IDX_Y_ACCEL_HIGH: rd_byte = y_sample_word[15:8];
            accel_regs_pkg::IDX_Z_ACCEL_LOW: rd_byte = z_sample_word[7:0];
            accel_regs_pkg::IDX_WATERMARK_CONFIG: rd_byte = {1'b0, watermark_level};
            accel_regs_pkg::IDX_IRQ_STATUS: rd_byte = {5'h00, irq_status};
            accel_regs_pkg::IDX_IRQ_MASK: rd_byte = {5'h00, irq_mask};
            default: rd_byte = 8'h00;
        endcase
    end

    // ==========================================================
    // Clear, write and edge strobes
    // ==========================================================
    assign hi_read = rd_take
        && (index == accel_regs_pkg::IDX_X_ACCEL_HIGH
        || index == accel_regs_pkg::IDX_Y_ACCEL_HIGH);
    assign wm_rise = watermark_reached & ~wm_prev;
    assign wr_watermark = wr_take && index == accel_regs_pkg::IDX_WATERMARK_CONFIG;
    assign wr_mask = wr_take && index == accel_regs_pkg::IDX_IRQ_MASK;
    assign rd_irq_status = rd_take && index == accel_regs_pkg::IDX_IRQ_STATUS;

    // ==========================================================
    // Bus answer
    // ==========================================================
    // One wait state gives the read decode a full cycle to settle.
    always_comb begin
        next_ack = (read | write) & ~ack;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ack <= 1'b0;
        end else begin
            ack <= next_ack;
        end
    end

    // ==========================================================
    // Read data
    // ==========================================================
    // Read data holds between reads, so a late sample still sees it.
    always_comb begin
        next_readdata = readdata;
        if (rd_take) begin
            next_readdata = {24'h000000, rd_byte};
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            readdata <= 32'h00000000;
        end else begin
            readdata <= next_readdata;
        end
    end

    // ==========================================================
    // Sample capture
    // ==========================================================
    always_comb begin
        next_sample_word = sample_word;
        if (sample_strobe) begin
            next_sample_word = sample_in;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            sample_word <= '0;
        end else begin
            sample_word <= next_sample_word;
        end
    end

    // ==========================================================
    // New-sample flag
    // ==========================================================
    // A fresh sample in the same cycle as the clearing read keeps the flag set.
    always_comb begin
        next_new_sample_flag = new_sample_flag;
        if (hi_read) begin
            next_new_sample_flag = 1'b0;
        end
        if (sample_strobe) begin
            next_new_sample_flag = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            new_sample_flag <= 1'b0;
        end else begin
            new_sample_flag <= next_new_sample_flag;
        end
    end

    // ==========================================================
    // Overrun flag
    // ==========================================================
    // Overrun holds until the queue drains empty, so a late host still sees it.
    always_comb begin
        next_queue_overrun = queue_overrun;
        if (!queue_overwrite && queue_sample_count == 8'h00) begin
            next_queue_overrun = 1'b0;
        end
        if (queue_overwrite) begin
            next_queue_overrun = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            queue_overrun <= 1'b0;
        end else begin
            queue_overrun <= next_queue_overrun;
        end
    end

    // ==========================================================
    // Watermark configuration
    // ==========================================================
    // Only byte lane 0 carries the level; the other lanes are ignored.
    always_comb begin
        next_watermark_level = watermark_level;
        if (wr_watermark) begin
            next_watermark_level = writedata[6:0];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            watermark_level <= accel_regs_pkg::RST_WATERMARK;
        end else begin
            watermark_level <= next_watermark_level;
        end
    end

    // ==========================================================
    // Interrupt mask
    // ==========================================================
    // Masking hides a bit from irq but leaves it visible in the status register.
    always_comb begin
        next_irq_mask = irq_mask;
        if (wr_mask) begin
            next_irq_mask = writedata[2:0];
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq_mask <= accel_regs_pkg::RST_IRQ_MASK;
        end else begin
            irq_mask <= next_irq_mask;
        end
    end

    // ==========================================================
    // Watermark edge
    // ==========================================================
    // Reset reads as already reached, since an empty queue meets a zero level.
    always_comb begin
        next_wm_prev = watermark_reached;
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            wm_prev <= 1'b1;
        end else begin
            wm_prev <= next_wm_prev;
        end
    end

    // ==========================================================
    // Interrupt status
    // ==========================================================
    // Set beats clear, so an event during the clearing read is not lost.
    always_comb begin
        next_irq_status = irq_status;
        if (rd_irq_status) begin
            next_irq_status = 3'h0;
        end
        if (sample_strobe) begin
            next_irq_status[accel_regs_pkg::IRQ_NEW_SAMPLE] = 1'b1;
        end
        if (wm_rise) begin
            next_irq_status[accel_regs_pkg::IRQ_WATERMARK] = 1'b1;
        end
        if (queue_overwrite) begin
            next_irq_status[accel_regs_pkg::IRQ_OVERRUN] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irq_status <= 3'h0;
        end else begin
            irq_status <= next_irq_status;
        end
    end
endmodule : accel_status_output_regs
`default_nettype wire

// >>> include/accel_regs_pkg.sv
/*
 * Package for the acceleration status and output register bank: register
 * offsets, field positions, reset values and the packed carriers.
 * Assumes a byte-indexed register map reached over a 32-bit word bus.
 */
package accel_regs_pkg;
    // ==========================================================
    // Register indexes and address width
    // ==========================================================
    localparam logic [7:0] IDX_SENSOR_STATUS = 8'h25;
    localparam logic [7:0] IDX_QUEUE_STATUS_FLAGS = 8'h26;
    localparam logic [7:0] IDX_QUEUE_FILL_COUNT = 8'h27;
    localparam logic [7:0] IDX_X_ACCEL_LOW = 8'h28;
    localparam logic [7:0] IDX_X_ACCEL_HIGH = 8'h29;
    localparam logic [7:0] IDX_Y_ACCEL_LOW = 8'h2A;
    localparam logic [7:0] IDX_Y_ACCEL_HIGH = 8'h2B;
    localparam logic [7:0] IDX_Z_ACCEL_LOW = 8'h2C;
    localparam logic [7:0] IDX_WATERMARK_CONFIG = 8'h16;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h41;
    localparam int ADDR_W = 10;
    // ==========================================================
    // Field positions
    // ==========================================================
    localparam int BIT_NEW_SAMPLE = 0;
    localparam int BIT_POWERDOWN = 1;
    localparam int BIT_OVERRUN = 6;
    localparam int BIT_WATERMARK = 7;
    localparam int IRQ_NEW_SAMPLE = 0;
    localparam int IRQ_WATERMARK = 1;
    localparam int IRQ_OVERRUN = 2;
    localparam int IRQ_W = 3;
    localparam int WTM_W = 7;
    localparam int LOW_ZERO_BITS = 4;
    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [6:0] RST_WATERMARK = 7'h00;
    localparam logic [2:0] RST_IRQ_MASK = 3'h0;
    localparam logic [15:0] RST_SAMPLE = 16'h0000;

    typedef struct packed {
        logic [11:0] x;
        logic [11:0] y;
        logic [11:0] z;
    } sample_t;

    typedef struct packed {
        logic new_sample;
        logic watermark;
        logic overrun;
    } irq_bits_t;
endpackage : accel_regs_pkg

// >>> verification/accel_regs_chk.sv
/* Assertions on the register bank ports.
   Assumes one clock and Avalon reads answered after one wait state. */
`timescale 1ns/100ps
`default_nettype none
module accel_regs_chk (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic [9:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic sample_strobe,
    input wire logic [7:0] queue_sample_count,
    input wire logic [6:0] watermark_level
);
    // ==========================================================
    // Read answers
    // ==========================================================
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    sequence s_hi_read;
        read && !waitrequest && address[9:2] == 8'h29 && !sample_strobe && !$past(sample_strobe);
    endsequence
    sequence s_stat_read; read && !waitrequest && address[9:2] == 8'h25; endsequence
    a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("no answer");
    a_upper_zero: assert property (read && !waitrequest |-> readdata[31:8] == 24'h0) else $error("upper bits");
    a_x_low: assert property (read && !waitrequest && address[9:2] == 8'h28 |-> readdata[3:0] == 4'h0)
        else $error("x low bits");
    a_y_low: assert property (read && !waitrequest && address[9:2] == 8'h2A |-> readdata[3:0] == 4'h0)
        else $error("y low bits");
    a_fill_count: assert property (read && !waitrequest && address[9:2] == 8'h27
        |-> readdata[7:0] == $past(queue_sample_count)) else $error("fill count");
    a_wtm_flag: assert property (read && !waitrequest && address[9:2] == 8'h26
        && $past(queue_sample_count) == $past(queue_sample_count, 2) && $past(watermark_level) == $past(watermark_level, 2)
        |-> readdata[7] == ($past(queue_sample_count) >= {1'b0, $past(watermark_level)})) else $error("watermark");
    a_flag_set: assert property ($past(sample_strobe, 2) ##0 s_stat_read |-> readdata[0]) else $error("flag set");
    a_flag_clear: assert property (s_hi_read ##1 !sample_strobe [*3] ##0 s_stat_read |-> !readdata[0])
        else $error("flag clear");
endmodule : accel_regs_chk
bind accel_status_output_regs accel_regs_chk chk (.sys_clk(sys_clk), .resetn(resetn), .address(address),
    .read(read), .write(write), .readdata(readdata), .waitrequest(waitrequest), .sample_strobe(sample_strobe),
    .queue_sample_count(queue_sample_count), .watermark_level(watermark_level));
`default_nettype wire

// >>> verification/accel_core_model.sv
/* Sensor core model that delivers one sample with a one-cycle strobe.
   Assumes emit is called just after a rising edge of sys_clk. */
`timescale 1ns/100ps
`default_nettype none
module accel_core_model (
    input wire logic sys_clk,
    output logic sample_strobe,
    output accel_regs_pkg::sample_t sample_in
);
    // ==========================================================
    // Sample delivery
    // ==========================================================
    initial begin
        sample_strobe = 1'b0;
        sample_in = '0;
    end
    // Data is scrambled after the strobe so a late capture shows up.
    task emit(input logic [11:0] x, input logic [11:0] y);
        sample_in <= {x, y, 12'h5A5};
        sample_strobe <= 1'b1;
        @(posedge sys_clk);
        sample_strobe <= 1'b0;
        sample_in <= ~sample_in;
    endtask : emit
endmodule : accel_core_model
`default_nettype wire

// >>> verification/tb_top.sv
/* Self-checking bench for the register bank over Avalon-MM.
   Assumes the partner model supplies samples; the bench drives the queue state. */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    // ==========================================================
    // Stimulus and checks
    // ==========================================================
    logic sys_clk = 1'b0, resetn = 1'b0, read = 1'b0, write = 1'b0, pd = 1'b0, ovw = 1'b0, strobe, irq, waitrequest;
    logic [9:0] address = 10'h000;
    logic [31:0] writedata = 32'h0, readdata;
    logic [7:0] count = 8'h00, r;
    logic [6:0] wlevel;
    accel_regs_pkg::sample_t smp;
    int error_cnt = 0, check_count = 0;
    initial forever #2 sys_clk = ~sys_clk;
    accel_core_model core (.sys_clk(sys_clk), .sample_strobe(strobe), .sample_in(smp));
    accel_status_output_regs dut (.sys_clk(sys_clk), .resetn(resetn), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata), .waitrequest(waitrequest),
        .sample_strobe(strobe), .sample_in(smp), .powerdown_indicator(pd), .queue_sample_count(count),
        .queue_overwrite(ovw), .watermark_level(wlevel), .irq(irq));
    task test_done;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : test_done
    task chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("Error %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    // Holds the request until waitrequest is seen low, then idles one cycle.
    task acc(input logic w, input logic [7:0] idx, input logic [7:0] wd);
        int n;
        n = 0;
        address <= {idx, 2'b00};
        read <= !w;
        write <= w;
        writedata <= {24'h0, wd};
        do begin
            @(posedge sys_clk);
            n++;
        end while (waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            test_done;
        end
        r = readdata[7:0];
        read <= 1'b0;
        write <= 1'b0;
        @(posedge sys_clk);
    endtask : acc
    initial begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        pd <= 1'b1;
        core.emit(12'hABC, 12'h123);
        acc(0, 8'h25, 0); chk(r, 8'h03);
        acc(0, 8'h28, 0); chk(r, 8'hC0);
        acc(0, 8'h29, 0); chk(r, 8'hAB);
        acc(0, 8'h25, 0); chk(r, 8'h02);
        acc(0, 8'h2A, 0); chk(r, 8'h30);
        acc(0, 8'h2C, 0); chk(r, 8'h50);
        core.emit(12'h456, 12'h789);
        acc(0, 8'h2B, 0); chk(r, 8'h78);
        acc(0, 8'h25, 0); chk(r, 8'h02);
        acc(0, 8'h30, 0); chk(r, 8'h00);
        $display("sample test done");
        count <= 8'h05;
        acc(1, 8'h16, 8'h05);
        acc(0, 8'h16, 0); chk(r, 8'h05);
        chk({1'b0, wlevel}, 8'h05);
        acc(1, 8'h27, 8'h11);
        acc(0, 8'h27, 0); chk(r, 8'h05);
        acc(0, 8'h26, 0); chk(r, 8'h80);
        count <= 8'h04;
        acc(0, 8'h26, 0); chk(r, 8'h00);
        ovw <= 1'b1;
        @(posedge sys_clk);
        ovw <= 1'b0;
        acc(0, 8'h26, 0); chk(r, 8'h40);
        $display("queue test done");
        chk({7'h0, irq}, 8'h00);
        acc(1, 8'h41, 8'h07); chk({7'h0, irq}, 8'h01);
        acc(0, 8'h40, 0); chk(r & 8'h05, 8'h05);
        chk({7'h0, irq}, 8'h00);
        $display("interrupt test done");
        test_done;
    end
endmodule : tb_top
`default_nettype wire
